// ==== pse_defines.svh ====
// Purpose: constants for the per-channel extreme and mean statistics block
// Assumes: APB register access, 32-bit words, one clock
// Notes:   offsets are byte addresses within a 4 KiB window
//
// Behaviour
// RULE_01: All statistics of all channels come from the same sample strobe in parallel.
// RULE_02: Each of the six channels has its own maximum, minimum and mean register.
// RULE_03: Every statistic covers the measurement period the block reports.
// RULE_04: A software-set symmetric input span scales every code to plus/minus that span.
// RULE_05: The maximum is a 12-bit offset-binary code in bits 15:4, bits 3:0 reserved.
// RULE_06: Maximum code is (peak plus span) over twice the span, times 4096.
// RULE_07: The minimum is a 12-bit offset-binary code in bits 15:4, bits 3:0 reserved.
// RULE_08: Minimum code is (lowest plus span) over twice the span, times 4096.
// RULE_09: The mean is a full 16-bit offset-binary code in bits 15:0.
// RULE_10: Mean code is (mean sample plus span) over twice the span, times 65536.
// RULE_11: At period end all registers update together, then trackers and sums restart; here registers update after conversion, skipping closes while busy.
// RULE_12: Codes outside the representable range saturate at the lowest or highest code.
`ifndef PSE_DEFINES_SVH
`define PSE_DEFINES_SVH

`define PSE_CHANNELS        6
`define PSE_SAMPLE_W        16
`define PSE_PERIOD_W        16
`define PSE_OP_W            36
`define PSE_FRAC_BITS       16
`define PSE_RESERVED_LSBS   4

`define PSE_ADDR_SPAN       12'h000
`define PSE_ADDR_PERIOD_LEN 12'h004
`define PSE_ADDR_STATUS     12'h008
`define PSE_ADDR_PERIOD_RES 12'h00C
`define PSE_ADDR_PEAK_HIGH  12'h040
`define PSE_ADDR_PEAK_LOW   12'h060
`define PSE_ADDR_MEAN       12'h080

`define PSE_STATUS_VALID    0
`define PSE_STATUS_OVERRUN  1
`define PSE_STATUS_BUSY     2

`define PSE_RST_SPAN        16'h7FFF
`define PSE_RST_PERIOD_LEN  16'h0400

`endif

// ==== pse_pkg.sv ====
// Purpose: shared types of the statistics block
// Assumes: pse_defines.svh supplies widths
// Notes:   none
`include "pse_defines.svh"

package pse_pkg;

	// six simultaneous two's-complement samples, channel 0 in the low word
	typedef struct packed
	{
		logic [`PSE_CHANNELS-1:0][`PSE_SAMPLE_W-1:0] value;
	} pse_samples_t;

	// divider operands for one result
	typedef struct packed
	{
		logic [`PSE_OP_W-1:0] num;
		logic [`PSE_OP_W-1:0] den;
		logic                 sat_low;
		logic                 sat_high;
	} pse_div_op_t;

	typedef enum logic [1:0]
	{
		st_idle,
		st_run,
		st_commit
	} pse_state_t;

endpackage

// ==== pse_phase_stats.sv ====
// Purpose: per-channel maximum, minimum and mean over a sample-counted period
// Assumes: samples and strobe come from logic on clk; APB slave on clk
// Notes:   one shared serial divider converts all 18 results after each period that closes while it is idle
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "pse_defines.svh"

module pse_phase_stats
#(
	parameter int PERIOD_W = `PSE_PERIOD_W
)
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire pse_pkg::pse_samples_t  samples,
	input  wire logic                   sample_valid,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic                        results_ready
);

	localparam int CH    = `PSE_CHANNELS;
	localparam int SW    = `PSE_SAMPLE_W;
	localparam int OW    = `PSE_OP_W;
	localparam int FB    = `PSE_FRAC_BITS;
	localparam int SUM_W = SW + PERIOD_W;

	// software settings
	logic        [SW-1:0]       input_span_setting;
	logic        [PERIOD_W-1:0] period_len;
	logic                       overrun;
	logic                       results_valid;

	// running trackers
	logic signed [SW-1:0]       run_max [CH];
	logic signed [SW-1:0]       run_min [CH];
	logic signed [SUM_W-1:0]    run_sum [CH];
	logic        [PERIOD_W-1:0] sample_cnt;
	logic signed [SW-1:0]       next_max [CH];
	logic signed [SW-1:0]       next_min [CH];
	logic signed [SUM_W-1:0]    next_sum [CH];
	logic        [PERIOD_W-1:0] len_eff;
	logic                       period_end;

	// snapshot of a closed period
	logic signed [SW-1:0]       snap_max [CH];
	logic signed [SW-1:0]       snap_min [CH];
	logic signed [SUM_W-1:0]    snap_sum [CH];
	logic        [PERIOD_W-1:0] snap_n;
	logic        [SW-1:0]       snap_span;
	logic                       take_snap;

	// conversion engine
	pse_pkg::pse_state_t        state;
	logic        [1:0]          job_kind;
	logic        [2:0]          job_ch;
	logic        [4:0]          step;
	logic        [OW:0]         rem;
	logic        [OW-1:0]       den;
	logic        [FB-1:0]       quot;
	logic                       sat_lo;
	logic                       sat_hi;
	logic signed [OW-1:0]       sel_val;
	pse_pkg::pse_div_op_t       cur_op;
	logic        [OW:0]         shifted;
	logic                       q_bit;
	logic        [OW:0]         next_rem;
	logic        [FB-1:0]       next_quot;
	logic        [FB-1:0]       job_code;

	// staged and published results
	logic        [15:0]         stage_high [CH];
	logic        [15:0]         stage_low  [CH];
	logic        [15:0]         stage_mean [CH];
	logic        [15:0]         peak_high  [CH];
	logic        [15:0]         peak_low   [CH];
	logic        [15:0]         mean_level_result [CH];
	logic        [PERIOD_W-1:0] period_result;

	// bus decode
	logic                       apb_access;
	logic                       apb_commit;
	logic        [31:0]         rd_data;
	logic                       rd_err;
	logic        [3:0]          idx_high;
	logic        [3:0]          idx_low;
	logic        [3:0]          idx_mean;

	// scaled operands: numerator (value plus offset) and denominator twice the scale
	function automatic pse_pkg::pse_div_op_t job_operands
	(
		input logic                       is_mean,
		input logic signed [OW-1:0]       val,
		input logic        [PERIOD_W-1:0] n,
		input logic        [SW-1:0]       span
	);
		logic signed [OW-1:0] r;
		logic signed [OW-1:0] scale;
		logic signed [OW-1:0] num;
		pse_pkg::pse_div_op_t op;
		r = (span == '0) ? OW'(1) : $signed(OW'(span));
		// RULE_10: mean scales by count
		scale = is_mean ? OW'($signed(OW'(n)) * r) : r;
		num = val + scale;
		op.num = num;
		op.den = scale <<< 1;
		// RULE_12: saturation limits
		op.sat_low  = (num <= 0);
		op.sat_high = (num >= (scale <<< 1));
		return op;
	endfunction

	// final code with saturation and reserved low bits
	function automatic logic [15:0] code_of
	(
		input logic          is_mean,
		input logic          lo,
		input logic          hi,
		input logic [FB-1:0] q
	);
		logic [15:0] c;
		c = hi ? 16'hFFFF : (lo ? 16'h0000 : q);
		// RULE_05: low bits reserved
		if (!is_mean)
		begin
			c[`PSE_RESERVED_LSBS-1:0] = '0;
		end
		return c;
	endfunction

	// word index within a six-word group, F when outside it
	function automatic logic [3:0] group_index
	(
		input logic [11:0] addr,
		input logic [11:0] base
	);
		logic [11:0] diff;
		diff = addr - base;
		if (addr >= base && diff[1:0] == 2'h0 && diff[11:2] < 10'(CH))
		begin
			return diff[5:2];
		end
		return 4'hF;
	endfunction

	assign len_eff = (period_len == '0) ? PERIOD_W'(1) : period_len;

	// RULE_03: period closes on the counted sample
	assign period_end = sample_valid && (sample_cnt == len_eff - PERIOD_W'(1));
	assign take_snap  = period_end && (state == pse_pkg::st_idle);

	// next tracker values, first sample of a period seeds them
	always_comb
	begin
		for (int c = 0; c < CH; c++)
		begin
			// RULE_01: all channels in parallel
			if (sample_cnt == '0)
			begin
				next_max[c] = $signed(samples.value[c]);
				next_min[c] = $signed(samples.value[c]);
				next_sum[c] = SUM_W'($signed(samples.value[c]));
			end
			else
			begin
				next_max[c] = ($signed(samples.value[c]) > run_max[c]) ?
					$signed(samples.value[c]) : run_max[c];
				next_min[c] = ($signed(samples.value[c]) < run_min[c]) ?
					$signed(samples.value[c]) : run_min[c];
				next_sum[c] = run_sum[c] + SUM_W'($signed(samples.value[c]));
			end
		end
	end

	// RULE_02: one tracker set per channel
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sample_cnt <= '0;
			for (int c = 0; c < CH; c++)
			begin
				run_max[c] <= '0;
				run_min[c] <= '0;
				run_sum[c] <= '0;
			end
		end
		else if (sample_valid)
		begin
			// RULE_11: restart after period end
			sample_cnt <= period_end ? '0 : sample_cnt + PERIOD_W'(1);
			for (int c = 0; c < CH; c++)
			begin
				run_max[c] <= next_max[c];
				run_min[c] <= next_min[c];
				run_sum[c] <= next_sum[c];
			end
		end
	end

	// snapshot of the closed period, taken only while the engine is free
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			snap_n    <= PERIOD_W'(1);
			snap_span <= `PSE_RST_SPAN;
			for (int c = 0; c < CH; c++)
			begin
				snap_max[c] <= '0;
				snap_min[c] <= '0;
				snap_sum[c] <= '0;
			end
		end
		else if (take_snap)
		begin
			snap_n    <= len_eff;
			// RULE_04: span sampled for the batch
			snap_span <= input_span_setting;
			for (int c = 0; c < CH; c++)
			begin
				snap_max[c] <= next_max[c];
				snap_min[c] <= next_min[c];
				snap_sum[c] <= next_sum[c];
			end
		end
	end

	// operand select for the current job
	always_comb
	begin
		if (job_kind == 2'd0)
		begin
			sel_val = OW'(snap_max[job_ch]);
		end
		else if (job_kind == 2'd1)
		begin
			sel_val = OW'(snap_min[job_ch]);
		end
		else
		begin
			sel_val = OW'(snap_sum[job_ch]);
		end
		cur_op = job_operands(job_kind == 2'd2, sel_val, snap_n, snap_span);
	end

	// one restoring-division step of the fraction num/den
	always_comb
	begin
		shifted   = {rem[OW-1:0], 1'b0};
		q_bit     = (shifted >= {1'b0, den});
		next_rem  = q_bit ? shifted - {1'b0, den} : shifted;
		next_quot = {quot[FB-2:0], q_bit};
		// RULE_06: max code from fraction
		// RULE_08: min code likewise
		job_code  = code_of(job_kind == 2'd2, sat_lo, sat_hi, next_quot);
	end

	// conversion sequencer: load, sixteen steps, store, next job
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state    <= pse_pkg::st_idle;
			job_kind <= '0;
			job_ch   <= '0;
			step     <= '0;
			rem      <= '0;
			den      <= '0;
			quot     <= '0;
			sat_lo   <= 1'b0;
			sat_hi   <= 1'b0;
		end
		else
		begin
			case (state)
				pse_pkg::st_idle:
				begin
					if (take_snap)
					begin
						state    <= pse_pkg::st_run;
						job_kind <= '0;
						job_ch   <= '0;
						step     <= '0;
					end
				end
				pse_pkg::st_run:
				begin
					if (step == 5'd0)
					begin
						sat_lo <= cur_op.sat_low;
						sat_hi <= cur_op.sat_high;
						rem    <= (cur_op.sat_low || cur_op.sat_high) ? '0 : {1'b0, cur_op.num};
						den    <= cur_op.den;
						quot   <= '0;
						step   <= 5'd1;
					end
					else
					begin
						rem  <= next_rem;
						quot <= next_quot;
						if (step == 5'(FB))
						begin
							step <= '0;
							if (job_ch == 3'(CH - 1))
							begin
								job_ch   <= '0;
								job_kind <= job_kind + 2'd1;
								if (job_kind == 2'd2)
								begin
									state <= pse_pkg::st_commit;
								end
							end
							else
							begin
								job_ch <= job_ch + 3'd1;
							end
						end
						else
						begin
							step <= step + 5'd1;
						end
					end
				end
				default:
				begin
					state <= pse_pkg::st_idle;
				end
			endcase
		end
	end

	// staging of finished codes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int c = 0; c < CH; c++)
			begin
				stage_high[c] <= '0;
				stage_low[c]  <= '0;
				stage_mean[c] <= '0;
			end
		end
		else if (state == pse_pkg::st_run && step == 5'(FB))
		begin
			if (job_kind == 2'd0)
			begin
				stage_high[job_ch] <= job_code;
			end
			else if (job_kind == 2'd1)
			begin
				// RULE_07: same 12-bit layout
				stage_low[job_ch] <= job_code;
			end
			else
			begin
				// RULE_09: full 16-bit mean
				stage_mean[job_ch] <= job_code;
			end
		end
	end

	// RULE_11: publish all at once
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			results_ready <= 1'b0;
			results_valid <= 1'b0;
			period_result <= '0;
			for (int c = 0; c < CH; c++)
			begin
				peak_high[c]         <= 16'h0000;
				peak_low[c]          <= 16'h0000;
				mean_level_result[c] <= 16'h0000;
			end
		end
		else
		begin
			results_ready <= (state == pse_pkg::st_commit);
			if (state == pse_pkg::st_commit)
			begin
				results_valid <= 1'b1;
				period_result <= snap_n;
				for (int c = 0; c < CH; c++)
				begin
					peak_high[c]         <= stage_high[c];
					peak_low[c]          <= stage_low[c];
					mean_level_result[c] <= stage_mean[c];
				end
			end
		end
	end

	assign apb_access = psel && penable;
	assign apb_commit = apb_access && pready && pwrite && !pslverr;

	// read decode
	always_comb
	begin
		idx_high = group_index(paddr, `PSE_ADDR_PEAK_HIGH);
		idx_low  = group_index(paddr, `PSE_ADDR_PEAK_LOW);
		idx_mean = group_index(paddr, `PSE_ADDR_MEAN);
		rd_data  = 32'h0000_0000;
		rd_err   = 1'b0;
		if (paddr == `PSE_ADDR_SPAN)
		begin
			rd_data = 32'(input_span_setting);
		end
		else if (paddr == `PSE_ADDR_PERIOD_LEN)
		begin
			rd_data = 32'(period_len);
		end
		else if (paddr == `PSE_ADDR_STATUS)
		begin
			rd_data[`PSE_STATUS_VALID]   = results_valid;
			rd_data[`PSE_STATUS_OVERRUN] = overrun;
			rd_data[`PSE_STATUS_BUSY]    = (state != pse_pkg::st_idle);
		end
		else if (paddr == `PSE_ADDR_PERIOD_RES)
		begin
			rd_data = 32'(period_result);
		end
		else if (idx_high != 4'hF)
		begin
			rd_data = {16'h0000, peak_high[idx_high[2:0]]};
		end
		else if (idx_low != 4'hF)
		begin
			rd_data = {16'h0000, peak_low[idx_low[2:0]]};
		end
		else if (idx_mean != 4'hF)
		begin
			rd_data = {16'h0000, mean_level_result[idx_mean[2:0]]};
		end
		else
		begin
			rd_err = 1'b1; // unmapped
		end
	end

	// apb answer: one wait state, registered data
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (apb_access && !pready)
		begin
			pready  <= 1'b1;
			pslverr <= rd_err;
			prdata  <= pwrite ? 32'h0000_0000 : rd_data;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// RULE_04: span and period writable
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			input_span_setting <= `PSE_RST_SPAN;
			period_len         <= PERIOD_W'(`PSE_RST_PERIOD_LEN);
		end
		else if (apb_commit && paddr == `PSE_ADDR_SPAN)
		begin
			input_span_setting <= pwdata[SW-1:0];
		end
		else if (apb_commit && paddr == `PSE_ADDR_PERIOD_LEN)
		begin
			period_len <= pwdata[PERIOD_W-1:0];
		end
	end

	// overrun flag: set wins over write-one-to-clear
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			overrun <= 1'b0;
		end
		else if (period_end && state != pse_pkg::st_idle)
		begin
			overrun <= 1'b1;
		end
		else if (apb_commit && paddr == `PSE_ADDR_STATUS && pwdata[`PSE_STATUS_OVERRUN])
		begin
			overrun <= 1'b0;
		end
	end

endmodule

// ==== pse_phase_stats_properties.sv ====
// Purpose: bus and result timing checks for the statistics block
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only the top module ports
`timescale 1ns/10ps
module pse_phase_stats_props
#(
	parameter int PERIOD_W = 16
)
(
	input wire logic                  clk,
	input wire logic                  rst,
	input wire pse_pkg::pse_samples_t samples,
	input wire logic                  sample_valid,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  results_ready
);
	logic mapped;
	// aligned addresses that hold a register
	assign mapped = (paddr[1:0] == 2'b00) && ((paddr <= 12'h00C)
		|| (paddr >= 12'h040 && paddr <= 12'h054)
		|| (paddr >= 12'h060 && paddr <= 12'h074)
		|| (paddr >= 12'h080 && paddr <= 12'h094));
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_taken;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	property p_wait_state;
		s_taken |=> s_answer;
	endproperty
	a_wait_state: assert property (p_wait_state) // bus timing
		else $error("access not answered after one wait state");
	property p_ready_cause;
		pready |-> $past(psel) && $past(penable);
	endproperty
	a_ready_cause: assert property (p_ready_cause) // bus timing
		else $error("answer without an access");
	property p_err_unmapped;
		pready && paddr[1:0] == 2'b00 && !mapped |-> pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped)
		else $error("unmapped address not refused");
	property p_err_mapped;
		pready && mapped |-> !pslverr;
	endproperty
	a_err_mapped: assert property (p_err_mapped)
		else $error("mapped register refused");
	property p_err_data;
		pready && pslverr |-> prdata == 32'h0000_0000;
	endproperty
	a_err_data: assert property (p_err_data)
		else $error("refused access returned data");
	property p_reserved_bits;
		pready && !pwrite && paddr >= 12'h040 && paddr <= 12'h074 |-> prdata[3:0] == 4'h0;
	endproperty
	a_reserved_bits: assert property (p_reserved_bits)
		else $error("reserved extreme bits not zero");
	property p_upper_zero;
		pready && !pwrite |-> prdata[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper read bits not zero");
	property p_result_pulse;
		results_ready |=> !results_ready [*8];
	endproperty
	a_result_pulse: assert property (p_result_pulse)
		else $error("result pulse too long or too close");
endmodule

// ==== pse_apb_master.sv ====
// Purpose: acquisition controller model, APB master
// Assumes: slave answers with pready at a rising edge
// Notes:   released address and data lines show inverted values
`timescale 1ns/10ps
module pse_apb_master
(
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// idle bus at time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// setup, access, hold until pready seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// ==== test_phase_stats_extremes_mean.sv ====
// Purpose: register-level test of extremes and mean per channel
// Assumes: periods of four samples and then of one sample, span 1000 sample units
// Notes:   expectations computed from the offset-binary formulas
`timescale 1ns/10ps
`include "pse_defines.svh"
module test_phase_stats_extremes_mean;
	logic                  clk;
	logic                  rst;
	pse_pkg::pse_samples_t samples;
	logic                  sample_valid;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [11:0]           paddr;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  results_ready;
	int                    fails;
	int                    total_checks;
	longint                span_v;
	pse_phase_stats #(.PERIOD_W(16)) i_pse_phase_stats (.clk(clk), .rst(rst),
		.samples(samples), .sample_valid(sample_valid), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .results_ready(results_ready));
	pse_apb_master i_pse_apb_master (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	// clock
	always #5 clk = ~clk;
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			fails++;
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] r;
		logic        e;
		i_pse_apb_master.xfer(1'b0, a, 32'h0000_0000, r, e);
		check(r, exp);
		check({31'h0, e}, {31'h0, ee});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		i_pse_apb_master.xfer(1'b1, a, d, r, e);
		check({31'h0, e}, 32'h0000_0000);
	endtask
	// sample of channel c, step k, period p
	function automatic longint sv(int p, int k, int c);
		return (p == 0) ? k * 113 - c * 90 - 200 : (c - 2) * 550 + k * 10;
	endfunction
	// offset-binary code of num/den, saturating
	function automatic logic [15:0] code(longint num, longint den, bit mean);
		longint q;
		if (num <= -span_v * den)
			return 16'h0000;
		if (num >= span_v * den)
			return mean ? 16'hFFFF : 16'hFFF0;
		q = ((num + span_v * den) * (mean ? 65536 : 4096)) / (2 * span_v * den);
		return mean ? q[15:0] : {q[11:0], 4'h0};
	endfunction
	task automatic feed(input int p);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			sample_valid <= 1'b1;
			for (int c = 0; c < 6; c++)
				samples.value[c] <= 16'(sv(p, k, c));
			@(posedge clk);
			sample_valid <= 1'b0;
		end
	endtask
	task automatic wait_res;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (results_ready !== 1'b1 && n < 1000);
		check({31'h0, results_ready}, 32'h1);
	endtask
	task automatic chk_all(input int p);
		longint mx, mn, sm, v;
		for (int c = 0; c < 6; c++)
		begin
			mx = -100000;
			mn = 100000;
			sm = 0;
			for (int k = 0; k < 4; k++)
			begin
				v = sv(p, k, c);
				sm += v;
				mx = (v > mx) ? v : mx;
				mn = (v < mn) ? v : mn;
			end
			rd(`PSE_ADDR_PEAK_HIGH + 12'(4 * c), {16'h0, code(mx, 1, 0)}, 1'b0);
			rd(`PSE_ADDR_PEAK_LOW + 12'(4 * c), {16'h0, code(mn, 1, 0)}, 1'b0);
			rd(`PSE_ADDR_MEAN + 12'(4 * c), {16'h0, code(sm, 4, 1)}, 1'b0);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial
	begin
		#200000;
		fails++;
		wrap_up;
	end
	// main sequence
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		samples = '0;
		sample_valid = 1'b0;
		fails = 0;
		total_checks = 0;
		span_v = 1000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`PSE_ADDR_SPAN, 32'h0000_7FFF, 1'b0);
		rd(`PSE_ADDR_PERIOD_LEN, 32'h0000_0400, 1'b0);
		rd(`PSE_ADDR_STATUS, 32'h0000_0000, 1'b0);
		rd(`PSE_ADDR_MEAN + 12'h014, 32'h0000_0000, 1'b0);
		wr(`PSE_ADDR_SPAN, 32'h0000_03E8);
		wr(`PSE_ADDR_PERIOD_LEN, 32'h0000_0004);
		rd(`PSE_ADDR_SPAN, 32'h0000_03E8, 1'b0);
		feed(0);
		wait_res;
		rd(`PSE_ADDR_STATUS, 32'h0000_0001, 1'b0);
		rd(`PSE_ADDR_PERIOD_RES, 32'h0000_0004, 1'b0);
		chk_all(0);
		wr(`PSE_ADDR_PEAK_HIGH, 32'hFFFF_FFFF);
		rd(`PSE_ADDR_PEAK_HIGH, {16'h0, code(sv(0, 3, 0), 1, 0)}, 1'b0);
		rd(12'h020, 32'h0000_0000, 1'b1);
		rd(12'h0A0, 32'h0000_0000, 1'b1);
		feed(1);
		wait_res;
		chk_all(1);
		// one-sample periods: later closes land while busy and set overrun
		wr(`PSE_ADDR_PERIOD_LEN, 32'h0000_0001);
		feed(0);
		rd(`PSE_ADDR_STATUS, 32'h0000_0007, 1'b0);
		wr(`PSE_ADDR_STATUS, 32'h0000_0002);
		rd(`PSE_ADDR_STATUS, 32'h0000_0005, 1'b0);
		wait_res;
		rd(`PSE_ADDR_PERIOD_RES, 32'h0000_0001, 1'b0);
		rd(`PSE_ADDR_STATUS, 32'h0000_0001, 1'b0);
		rd(`PSE_ADDR_MEAN, {16'h0, code(sv(0, 0, 0), 1, 1)}, 1'b0);
		rd(`PSE_ADDR_PEAK_LOW, {16'h0, code(sv(0, 0, 0), 1, 0)}, 1'b0);
		wrap_up;
	end
endmodule
bind pse_phase_stats pse_phase_stats_props #(.PERIOD_W(PERIOD_W)) i_pse_phase_stats_props (
	.clk(clk), .rst(rst), .samples(samples), .sample_valid(sample_valid), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .results_ready(results_ready));
